// ---- second_stage_config_regs.sv ----
// second-stage converter configuration bank behind an Avalon-MM slave
// assumes a single 50 MHz clock, synchronous active-high reset, and that only the
// zero-current comparator input arrives from outside the clock domain
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stage2_cfg_defs.svh"

// Overview of operation
// - minimum peak code field is unsigned 0..7
// - peak code combined with clamp code
// - channel-1 gain field unsigned 0..63
// - compensated time subtracts scaled zcd rise time
// - sync bit enables sync pin drive
// - polarity bit selects zcd comparator sense
// - minimum dim floor from sixteen-step field
// - target period capped by 128-step limit
module second_stage_config_regs #(
  parameter int TIME_W = 16,
  parameter int DIM_W  = 12,
  parameter int PER_W  = 17
) (
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [7:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic [1:0]        clamp_code_i,
  input  wire logic              t2_comp_en_i,
  input  wire logic [TIME_W-1:0] secondary_time_i,
  input  wire logic [TIME_W-1:0] zcd_rise_time_i,
  input  wire logic              sync_channel_i,
  input  wire logic              zcd_raw_i,
  input  wire logic [DIM_W-1:0]  dim_level_i,
  input  wire logic [PER_W-1:0]  target_period_i,
  output logic      [4:0]        peak_floor_code_o,
  output logic      [TIME_W-1:0] t2_comp_o,
  output logic                   sync_o,
  output logic                   sync_oe_n_o,
  output logic                   zcd_event_o,
  output logic      [DIM_W-1:0]  dim_level_o,
  output logic      [DIM_W-1:0]  dim_floor_o,
  output logic      [PER_W-1:0]  period_limit_o,
  output logic      [PER_W-1:0]  target_period_o
);
  import stage2_cfg_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  bus_state_t        state_reg;
  logic              waitrequest_reg;
  logic [31:0]       readdata_reg;
  logic [31:0]       read_next;
  logic              wr_fire;
  cfg_byte_t         config_three_reg;
  cfg_byte_t         config_four_reg;
  cfg_byte_t         min_dim_reg;
  cfg_byte_t         period_max_reg;
  logic              zcd_meta_reg;
  logic              zcd_sync_reg;
  logic              zcd_event_reg;
  logic              sync_reg;
  logic              sync_oe_n_reg;
  logic [4:0]        peak_floor_reg;
  logic [TIME_W-1:0] t2_comp_reg;
  logic [TIME_W-1:0] t2_comp_next;
  logic [DIM_W-1:0]  dim_level_reg;
  logic [DIM_W-1:0]  dim_eff_next;
  logic [DIM_W-1:0]  dim_floor_reg;
  logic [DIM_W-1:0]  dim_floor_next;
  logic [PER_W-1:0]  period_limit_reg;
  logic [PER_W-1:0]  period_limit_next;
  logic [PER_W-1:0]  period_eff_reg;
  logic [PER_W-1:0]  period_eff_next;
  logic [1:0]        rst_age_reg;

  logic [2:0]        min_peak_code;
  logic [5:0]        ch1_secondary_time_gain;
  logic              sync_enable;
  logic              zero_current_polarity;

  assign min_peak_code           = config_three_reg[`PEAK_MSB:`PEAK_LSB];
  assign ch1_secondary_time_gain = config_four_reg[`GAIN_MSB:`GAIN_LSB];
  assign sync_enable             = config_four_reg[`SYNC_EN_BIT];
  assign zero_current_polarity   = config_four_reg[`ZCD_POL_BIT];

  function automatic logic [7:0] byte_addr(input cfg_byte_t idx);
    byte_addr = {idx[5:0], 2'b00};
  endfunction

  function automatic logic lane_hit(input logic [7:0] addr, input logic [3:0] be, input cfg_byte_t idx);
    lane_hit = (addr == byte_addr(idx)) && be[0];
  endfunction

  // ****************************************************************
  // avalon slave handshake
  // ****************************************************************
  // every access takes one wait cycle; the transfer completes in the ack cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= BUS_IDLE;
    end else begin
      case (state_reg)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            state_reg <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          state_reg <= BUS_IDLE;
        end
        default: begin
          state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= !((state_reg == BUS_IDLE) && (avs_read_i || avs_write_i));
    end
  end

  assign wr_fire = (state_reg == BUS_ACK) && avs_write_i;

  always_comb begin
    read_next = 32'h0000_0000;
    if (avs_address_i == byte_addr(`IDX_CONFIG_THREE)) begin
      read_next[7:0] = config_three_reg & `MASK_CONFIG_THREE;
    end else if (avs_address_i == byte_addr(`IDX_CONFIG_FOUR)) begin
      read_next[7:0] = config_four_reg;
    end else if (avs_address_i == byte_addr(`IDX_MIN_DIM)) begin
      read_next[7:0] = min_dim_reg;
    end else if (avs_address_i == byte_addr(`IDX_PERIOD_LIMIT)) begin
      read_next[7:0] = period_max_reg;
    end else begin
      read_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      readdata_reg <= 32'h0000_0000;
    end else if ((state_reg == BUS_IDLE) && avs_read_i) begin
      readdata_reg <= read_next;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      config_three_reg <= `RST_CONFIG_THREE;
    end else if (wr_fire && lane_hit(avs_address_i, avs_byteenable_i, `IDX_CONFIG_THREE)) begin
      config_three_reg <= avs_writedata_i[7:0] & `MASK_CONFIG_THREE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      config_four_reg <= `RST_CONFIG_FOUR;
    end else if (wr_fire && lane_hit(avs_address_i, avs_byteenable_i, `IDX_CONFIG_FOUR)) begin
      config_four_reg <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      min_dim_reg <= `RST_MIN_DIM;
    end else if (wr_fire && lane_hit(avs_address_i, avs_byteenable_i, `IDX_MIN_DIM)) begin
      min_dim_reg <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      period_max_reg <= `RST_PERIOD_LIMIT;
    end else if (wr_fire && lane_hit(avs_address_i, avs_byteenable_i, `IDX_PERIOD_LIMIT)) begin
      period_max_reg <= avs_writedata_i[7:0];
    end
  end

  // ****************************************************************
  // zero-current detect and sync pin
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      zcd_meta_reg  <= 1'b0;
      zcd_sync_reg  <= 1'b0;
      zcd_event_reg <= 1'b0;
    end else begin
      zcd_meta_reg  <= zcd_raw_i;
      zcd_sync_reg  <= zcd_meta_reg;
      // polarity bit clear inverts the active-low comparator output to an active-high event; set passes it through
      zcd_event_reg <= zero_current_polarity ? zcd_sync_reg : !zcd_sync_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sync_reg      <= 1'b0;
      sync_oe_n_reg <= 1'b1;
    end else begin
      sync_reg      <= sync_enable && sync_channel_i;
      sync_oe_n_reg <= !sync_enable;
    end
  end

  // ****************************************************************
  // derived limits
  // ****************************************************************
  stage2_derive #(
    .TIME_W(TIME_W),
    .DIM_W (DIM_W),
    .PER_W (PER_W)
  ) u_derive (
    .comp_en_i      (t2_comp_en_i),
    .gain_i         (ch1_secondary_time_gain),
    .meas_time_i    (secondary_time_i),
    .zcd_rise_time_i(zcd_rise_time_i),
    .min_dim_i      (min_dim_reg),
    .period_max_i   (period_max_reg),
    .dim_req_i      (dim_level_i),
    .period_req_i   (target_period_i),
    .t2_comp_o      (t2_comp_next),
    .dim_floor_o    (dim_floor_next),
    .dim_eff_o      (dim_eff_next),
    .period_limit_o (period_limit_next),
    .period_eff_o   (period_eff_next)
  );

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      peak_floor_reg <= 5'h00;
    end else begin
      peak_floor_reg <= {clamp_code_i, min_peak_code};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      t2_comp_reg      <= '0;
      dim_level_reg    <= '0;
      dim_floor_reg    <= '0;
      period_limit_reg <= '0;
      period_eff_reg   <= '0;
    end else begin
      t2_comp_reg      <= t2_comp_next;
      dim_level_reg    <= dim_eff_next;
      dim_floor_reg    <= dim_floor_next;
      period_limit_reg <= period_limit_next;
      period_eff_reg   <= period_eff_next;
    end
  end

  assign avs_readdata_o    = readdata_reg;
  assign avs_waitrequest_o = waitrequest_reg;
  assign peak_floor_code_o = peak_floor_reg;
  assign t2_comp_o         = t2_comp_reg;
  assign sync_o            = sync_reg;
  assign sync_oe_n_o       = sync_oe_n_reg;
  assign zcd_event_o       = zcd_event_reg;
  assign dim_level_o       = dim_level_reg;
  assign dim_floor_o       = dim_floor_reg;
  assign period_limit_o    = period_limit_reg;
  assign target_period_o   = period_eff_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rst_age_reg <= 2'h0;
    end else if (rst_age_reg != 2'h3) begin
      rst_age_reg <= rst_age_reg + 2'h1;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_peak_code_track: assert property ((rst_age_reg == 2'h3) |-> peak_floor_code_o[2:0] == $past(config_three_reg[3:1]))
    else $error("peak code output does not follow register field");
  a_peak_clamp_join: assert property ((rst_age_reg == 2'h3) |-> peak_floor_code_o[4:3] == $past(clamp_code_i))
    else $error("clamp code not joined with peak code");
  a_t2_zero_gain: assert property ((rst_age_reg == 2'h3) && (ch1_secondary_time_gain == 6'h00) |=> t2_comp_o == $past(secondary_time_i))
    else $error("zero gain altered secondary time");
  a_t2_unit_gain: assert property (t2_comp_en_i && (ch1_secondary_time_gain == 6'h10) && (zcd_rise_time_i <= secondary_time_i)
                   |=> t2_comp_o == $past(secondary_time_i) - $past(zcd_rise_time_i))
    else $error("unit gain compensation wrong");
  a_sync_disable: assert property (wr_fire && lane_hit(avs_address_i, avs_byteenable_i, `IDX_CONFIG_FOUR) && !avs_writedata_i[1]
                   |-> ##2 (sync_oe_n_o && !sync_o))
    else $error("sync pin still driven after disable");
  a_sync_drive: assert property (sync_enable && sync_channel_i |=> (!sync_oe_n_o && sync_o))
    else $error("sync pin not driven while enabled");
  a_zcd_polarity: assert property ((rst_age_reg == 2'h3)
                   |-> zcd_event_o == ($past(zero_current_polarity) ? $past(zcd_raw_i, 3) : !$past(zcd_raw_i, 3)))
    else $error("zero-current event polarity wrong");
  a_dim_floor_val: assert property ((rst_age_reg == 2'h3) |-> dim_floor_o == {$past(min_dim_reg), 4'hF} && dim_level_o >= dim_floor_o)
    else $error("minimum dim floor not enforced");
  a_period_cap: assert property ((rst_age_reg == 2'h3) && (period_max_reg == 8'h00) |=> period_limit_o == 17'h0013D
                   && target_period_o <= 17'h0013D)
    else $error("target period limit wrong");
  a_reserved_read: assert property ((state_reg == BUS_IDLE) && avs_read_i && (avs_address_i == byte_addr(`IDX_CONFIG_THREE))
                   |=> !avs_waitrequest_o && !avs_readdata_o[0])
    else $error("reserved bit read back as one");

  c_write_four: cover property (wr_fire && lane_hit(avs_address_i, avs_byteenable_i, `IDX_CONFIG_FOUR));
  c_read_done: cover property (avs_read_i && !avs_waitrequest_o);
  c_sync_high: cover property (sync_o && !sync_oe_n_o);
  c_dim_raised: cover property (dim_level_o == dim_floor_o && dim_floor_o != 12'h00F);
endmodule // second_stage_config_regs
`default_nettype wire

// ---- stage2_cfg_defs.svh ----
// offsets, field positions, reset values and timing counts of the second-stage configuration bank
// assumes inclusion by bare name from every file that decodes or scales these registers
`ifndef STAGE2_CFG_DEFS_SVH
`define STAGE2_CFG_DEFS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_CONFIG_THREE   8'h23
`define IDX_CONFIG_FOUR    8'h24
`define IDX_MIN_DIM        8'h25
`define IDX_PERIOD_LIMIT   8'h26

// ****************************************************************
// reset values and write masks
// ****************************************************************
`define RST_CONFIG_THREE   8'h00
`define RST_CONFIG_FOUR    8'h00
`define RST_MIN_DIM        8'h00
`define RST_PERIOD_LIMIT   8'h00
`define MASK_CONFIG_THREE  8'hFE

// ****************************************************************
// field positions
// ****************************************************************
`define PEAK_MSB           3
`define PEAK_LSB           1
`define GAIN_MSB           7
`define GAIN_LSB           2
`define SYNC_EN_BIT        1
`define ZCD_POL_BIT        0

// ****************************************************************
// scaling and timing
// ****************************************************************
`define GAIN_FRAC_BITS     4
`define DIM_STEP           16
`define DIM_OFFSET         15
`define DIM_FULL_SCALE     4095
`define PERIOD_STEP        128
`define PERIOD_OFFSET      127
`define PERIOD_UNIT_NS     50
`define CLK_PERIOD_NS      20

`endif

// ---- stage2_cfg_pkg.sv ----
// types shared by the second-stage configuration bank
// assumes nothing beyond a SystemVerilog compiler
package stage2_cfg_pkg;
  typedef logic [7:0] cfg_byte_t;
  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// ---- stage2_derive.sv ----
// combinational scaling of configuration fields into second-stage limits
// assumes all inputs come from flops on the same clock; the caller registers the outputs
`timescale 1ns/1ps
`default_nettype none
`include "stage2_cfg_defs.svh"
module stage2_derive #(
  parameter int TIME_W = 16,
  parameter int DIM_W  = 12,
  parameter int PER_W  = 17
) (
  input  wire logic                      comp_en_i,
  input  wire logic [5:0]                gain_i,
  input  wire logic [TIME_W-1:0]         meas_time_i,
  input  wire logic [TIME_W-1:0]         zcd_rise_time_i,
  input  wire stage2_cfg_pkg::cfg_byte_t min_dim_i,
  input  wire stage2_cfg_pkg::cfg_byte_t period_max_i,
  input  wire logic [DIM_W-1:0]          dim_req_i,
  input  wire logic [PER_W-1:0]          period_req_i,
  output logic      [TIME_W-1:0]         t2_comp_o,
  output logic      [DIM_W-1:0]          dim_floor_o,
  output logic      [DIM_W-1:0]          dim_eff_o,
  output logic      [PER_W-1:0]          period_limit_o,
  output logic      [PER_W-1:0]          period_eff_o
);
  import stage2_cfg_pkg::*;

  localparam int PROD_W = TIME_W + 6;

  logic [PROD_W-1:0] zcd_scaled;
  logic [14:0]       period_ticks;
  logic [21:0]       period_ns;

  function automatic logic [DIM_W-1:0] raise_to(input logic [DIM_W-1:0] v, input logic [DIM_W-1:0] lo);
    raise_to = (v < lo) ? lo : v;
  endfunction

  function automatic logic [PER_W-1:0] cap_at(input logic [PER_W-1:0] v, input logic [PER_W-1:0] hi);
    cap_at = (v > hi) ? hi : v;
  endfunction

  // gain is a 1/16 fixed-point factor
  assign zcd_scaled = (PROD_W'(zcd_rise_time_i) * PROD_W'(gain_i)) >> `GAIN_FRAC_BITS;

  always_comb begin
    if (!comp_en_i) begin
      t2_comp_o = meas_time_i;
    end else if (zcd_scaled >= PROD_W'(meas_time_i)) begin
      t2_comp_o = '0;
    end else begin
      t2_comp_o = meas_time_i - zcd_scaled[TIME_W-1:0];
    end
  end

  assign dim_floor_o  = DIM_W'(12'(min_dim_i) * 12'(`DIM_STEP) + 12'(`DIM_OFFSET));
  assign dim_eff_o    = raise_to(dim_req_i, dim_floor_o);

  // limit in 50 ns ticks, then converted to clock cycles rounding down
  assign period_ticks   = 15'(period_max_i) * 15'(`PERIOD_STEP) + 15'(`PERIOD_OFFSET);
  assign period_ns      = 22'(period_ticks) * 22'(`PERIOD_UNIT_NS);
  assign period_limit_o = PER_W'(period_ns / 22'(`CLK_PERIOD_NS));
  assign period_eff_o   = cap_at(period_req_i, period_limit_o);
endmodule // stage2_derive
`default_nettype wire

// ---- stage2_power_model.sv ----
// behavioural second-stage power stage: sense timings, zero-current comparator and channel
// assumes the bench starts each switching period with a one-cycle load_i on mclk_i
`timescale 1ns/1ps
`default_nettype none
module stage2_power_model (
  input  wire logic        mclk_i,
  input  wire logic        load_i,
  input  wire logic [15:0] meas_i,
  input  wire logic [15:0] rise_i,
  input  wire logic        zero_i,
  input  wire logic        pol_i,
  output logic      [15:0] secondary_time_o,
  output logic      [15:0] zcd_rise_time_o,
  output logic             zcd_raw_o,
  output logic             sync_channel_o
);
  logic zero_reg;

  initial begin
    secondary_time_o = 16'h0000;
    zcd_rise_time_o  = 16'h0000;
    sync_channel_o   = 1'b0;
    zero_reg         = 1'b0;
  end

  // a new gate period alternates the served channel and latches fresh sense timings
  always @(posedge mclk_i) begin
    if (load_i) begin
      secondary_time_o <= meas_i;
      zcd_rise_time_o  <= rise_i;
      zero_reg         <= zero_i;
      sync_channel_o   <= ~sync_channel_o;
    end
  end

  // comparator output sense follows the fitted comparator wiring
  assign zcd_raw_o = pol_i ? zero_reg : ~zero_reg;
endmodule // stage2_power_model
`default_nettype wire

// ---- test_second_stage_config_regs.sv ----
// self-checking bench for the second-stage configuration bank
// assumes the design files and stage2_power_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "stage2_cfg_defs.svh"
module test_second_stage_config_regs;
  import stage2_cfg_pkg::*;
  localparam logic [7:0] A3 = `IDX_CONFIG_THREE << 2;
  localparam logic [7:0] A4 = `IDX_CONFIG_FOUR << 2;
  localparam logic [7:0] AD = `IDX_MIN_DIM << 2;
  localparam logic [7:0] AT = `IDX_PERIOD_LIMIT << 2;
  logic        clk, rst, rd, wr, wait_req, comp_en, chan, zraw, zev, sync, sync_oe_n, load, zero, pol;
  logic [7:0]  adr;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic [1:0]  clamp;
  logic [15:0] meas, rise, t2_meas, t2_rise, t2_comp;
  logic [11:0] dim_in, dim_out, dim_floor;
  logic [16:0] per_in, per_lim, per_out;
  logic [4:0]  peak;
  logic [31:0] q;
  cfg_byte_t   c3, c4, mdim, tpm;
  int          err_total, checked, cyc;

  second_stage_config_regs i_dut (
    .mclk_i(clk), .sys_rst_i(rst), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .clamp_code_i(clamp), .t2_comp_en_i(comp_en),
    .secondary_time_i(t2_meas), .zcd_rise_time_i(t2_rise), .sync_channel_i(chan),
    .zcd_raw_i(zraw), .dim_level_i(dim_in), .target_period_i(per_in),
    .peak_floor_code_o(peak), .t2_comp_o(t2_comp), .sync_o(sync), .sync_oe_n_o(sync_oe_n),
    .zcd_event_o(zev), .dim_level_o(dim_out), .dim_floor_o(dim_floor),
    .period_limit_o(per_lim), .target_period_o(per_out));

  stage2_power_model i_plant (
    .mclk_i(clk), .load_i(load), .meas_i(meas), .rise_i(rise), .zero_i(zero), .pol_i(pol),
    .secondary_time_o(t2_meas), .zcd_rise_time_o(t2_rise), .zcd_raw_o(zraw), .sync_channel_o(chan));

  // ********
  // expectations
  // ********
  function automatic logic [15:0] exp_t2(input logic en, input logic [15:0] m, z, input logic [5:0] g);
    logic [21:0] p;
    p = z * g;
    if (!en) return m;
    return ({4'h0, p[21:4]} > {6'h00, m}) ? 16'h0000 : m - p[19:4];
  endfunction

  function automatic logic [11:0] exp_floor(input cfg_byte_t t);
    int v;
    v = t * `DIM_STEP + `DIM_OFFSET;
    return v[11:0];
  endfunction

  function automatic logic [16:0] exp_lim(input cfg_byte_t t);
    int v;
    v = (t * `PERIOD_STEP + `PERIOD_OFFSET) * `PERIOD_UNIT_NS / `CLK_PERIOD_NS;
    return v[16:0];
  endfunction

  // ********
  // checks and bus cycles
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input cfg_byte_t d, input logic [3:0] e);
    int n;
    n = 0;
    @(posedge clk);
    adr   <= a;
    rd    <= ~w;
    wr    <= w;
    wdata <= {24'($urandom()), d};
    be    <= e;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk(n < 20, 1, "bus answer");
  endtask

  task automatic rd_chk(input logic [7:0] a, input cfg_byte_t e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(q, {24'h000000, e}, "read back");
  endtask

  task automatic check_outs();
    logic [11:0] fl;
    logic [16:0] lim;
    fl  = exp_floor(mdim);
    lim = exp_lim(tpm);
    @(negedge clk);
    chk(peak, {clamp, c3[3:1]}, "peak code");
    chk(t2_comp, exp_t2(comp_en, meas, rise, c4[7:2]), "t2 comp");
    chk({sync_oe_n, sync}, c4[1] ? {1'b0, chan} : 2'b10, "sync pin");
    chk(zev, zero, "zcd event");
    chk(dim_floor, fl, "dim floor");
    chk(dim_out, dim_in > fl ? dim_in : fl, "dim level");
    chk(per_lim, lim, "period limit");
    chk(per_out, per_in < lim ? per_in : lim, "target period");
  endtask

  // one gate period under a fresh configuration, then readback of the bank
  task automatic step(input cfg_byte_t n3, n4, nd, nt);
    bus(1'b1, A3, n3, 4'hF);
    c3 = n3 & `MASK_CONFIG_THREE;
    bus(1'b1, A4, n4, 4'hF);
    c4 = n4;
    bus(1'b1, AD, nd, 4'hF);
    mdim = nd;
    bus(1'b1, AT, nt, 4'hF);
    tpm = nt;
    @(posedge clk);
    clamp   <= 2'($urandom());
    comp_en <= 1'($urandom());
    dim_in  <= 12'($urandom());
    per_in  <= 17'($urandom());
    meas    <= 16'($urandom());
    rise    <= 16'($urandom());
    zero    <= 1'($urandom());
    pol     <= n4[0];
    load    <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    repeat (5) @(posedge clk);
    check_outs();
    rd_chk(A3, c3);
    rd_chk(A4, c4);
    rd_chk(AD, mdim);
    rd_chk(AT, tpm);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      $display("mismatch at %0t: run did not finish in time", $time);
      test_done();
    end
  end

  // ********
  // main sequence
  // ********
  initial begin
    {rst, rd, wr, adr, wdata, be, clamp, comp_en, dim_in, per_in} = {1'b1, 78'h0};
    {meas, rise, zero, pol, load, c3, c4, mdim, tpm} = 67'h0;
    {err_total, checked, cyc} = 96'h0;
    void'($urandom(32'h053df946));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(A3, 8'h00);
    rd_chk(A4, 8'h00);
    rd_chk(AD, 8'h00);
    rd_chk(AT, 8'h00);
    check_outs();
    bus(1'b1, A3, 8'hFF, 4'hF);
    rd_chk(A3, 8'hFE);
    c3 = 8'hFE;
    bus(1'b1, A4, 8'hA5, 4'hE);
    rd_chk(A4, 8'h00);
    bus(1'b1, 8'h9C, 8'h5A, 4'hF);
    rd_chk(8'h9C, 8'h00);
    rd_chk(A3, 8'hFE);
    step(8'hFF, 8'hFF, 8'hFF, 8'hFF);
    step(8'h01, 8'hFC, 8'h00, 8'h00);
    step(8'h0E, 8'h03, 8'h80, 8'h7F);
    repeat (40) step(8'($urandom()), 8'($urandom()), 8'($urandom()), 8'($urandom()));
    step(8'h0E, 8'h42, 8'h10, 8'h20);
    test_done();
  end
endmodule // test_second_stage_config_regs
`default_nettype wire
